// File: rtl/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// Register indices; byte address is four times the index.
`define IDX_CONTROL 10'h0B0
`define IDX_COUNTER 10'h0B2
`define IDX_COMPARE 10'h0B3
`define IDX_STATUS 10'h0B6
`define IDX_FLAGS 10'h0B7
`define IDX_PIN_DIR 10'h0B8
// Field positions.
`define CTL_FORCE 7
`define ST_EXT_CLK 4
`define ST_ASYNC 3
`define FLG_MATCH 1
// Staging channel numbers, equal to their pending bit positions in the status register.
`define CH_CONTROL 0
`define CH_COMPARE 1
`define CH_COUNTER 2
`define RST_BYTE 8'h00
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define CNT_ONE 8'h01
`define OSC_EDGES_LAST 2'h1
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// File: rtl/timer_pkg.sv
package timer_pkg;
	typedef enum logic [1:0] {
		WAVE_NORMAL,
		WAVE_PHASE_PWM,
		WAVE_CLEAR_MATCH,
		WAVE_FAST_PWM
	} wave_t;

	// Control byte, bit 7 down to bit 0.
	typedef struct packed {
		logic force_match;
		logic wave_lo;
		logic [1:0] compare_output_mode;
		logic wave_hi;
		logic [2:0] clock_prescale_sel;
	} ctrl_t;
endpackage : timer_pkg

// File: rtl/async_timer_compare_output.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer_defines.svh"
// Summary of operation
// - Nonzero output mode drives pin; driver enabled only with direction bit set.
// - Non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at bottom, 11 inverse, 01 reserved.
// - Fast PWM, compare at top, upper mode bit: ignore match, still act at bottom.
// - Phase PWM: 10 clears on up-match, sets on down-match; 11 inverts.
// - Phase PWM, compare at top, upper mode bit: ignore match, act at top.
// - Prescale: 000 stop, 001 undivided, then 8,32,64,128,256,1024.
// - Counter readable live (two clocks late in async mode) and writable to load.
// - Counter write suppresses the compare match of the next timer tick.
// - Compare value continuously matched; match sets flag and shapes the pin.
// - External clock bit with async enables buffer; crystal runs only when bit zero.
// - Async select bit picks oscillator pin, else the system clock.
// - Changing clock source may corrupt timer registers; software rewrites them.
// - Async counter write sets its pending flag, cleared after transfer.
// - Async compare write sets its pending flag, cleared after transfer.
// - Async control write sets its pending flag, cleared after it takes effect.
// - Counter read returns live count, two clocks late in async mode; compare and control return staged values.
// - Staged writes transfer after two oscillator rising edges, each independently.
// - Mode 0 normal, 1 phase PWM, 2 clear on match with compare top, 3 fast.
// - Match sets flag; cleared by vector acknowledge or writing one.
module async_timer_compare_output (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_in_pin,
	input wire logic compare_vector_ack,
	output logic compare_output_pin,
	output logic compare_output_oe,
	output logic ext_clk_buf_en,
	output logic crystal_osc_run,
	output logic compare_match_flag
);
	// ==========================================================
	// Bus slave
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	wire logic aw_take = s_axi_awvalid && !aw_hold_q && !bvalid_q;
	wire logic w_take = s_axi_wvalid && !w_hold_q && !bvalid_q;
	wire logic do_write = aw_hold_q && w_hold_q && !bvalid_q;
	wire logic ar_take = s_axi_arvalid && !rvalid_q;
	wire logic [9:0] widx = awaddr_q[11:2];
	wire logic [9:0] ridx = s_axi_araddr[11:2];
	wire logic wr_lane = do_write && wstrb_q[0];
	wire logic [7:0] wbyte = wdata_q[7:0];
	wire logic wr_ctrl = wr_lane && (widx == `IDX_CONTROL);
	wire logic wr_cnt = wr_lane && (widx == `IDX_COUNTER);
	wire logic wr_cmp = wr_lane && (widx == `IDX_COMPARE);
	wire logic wr_stat = wr_lane && (widx == `IDX_STATUS);
	wire logic wr_flag = wr_lane && (widx == `IDX_FLAGS);
	wire logic wr_dir = wr_lane && (widx == `IDX_PIN_DIR);
	wire logic w_mapped = (widx == `IDX_CONTROL) || (widx == `IDX_COUNTER) ||
		(widx == `IDX_COMPARE) || (widx == `IDX_STATUS) || (widx == `IDX_FLAGS) ||
		(widx == `IDX_PIN_DIR);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `AXI_OKAY;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= w_mapped ? `AXI_OKAY : `AXI_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Registers and staging
	timer_pkg::ctrl_t ctrl_stage_q, ctrl_act_q;
	logic [7:0] cmp_stage_q, cmp_act_q, cnt_stage_q, cnt_q, cnt_s1_q, cnt_s2_q;
	logic ext_clk_q, async_q, dir_q, osc_q, up_q, blk_q, oc_q, flag_q;
	logic [9:0] pre_q;
	logic [2:0] pend_q, done;
	wire logic osc_rise = osc_in_pin && !osc_q;
	wire logic [2:0] wr_stage = {wr_cnt, wr_cmp, wr_ctrl} & {3{async_q}};

	// Each staged register counts oscillator edges on its own.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stage
			logic [1:0] edges_q;
			assign done[gi] = pend_q[gi] && osc_rise && (edges_q == `OSC_EDGES_LAST);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pend_q[gi] <= 1'b0;
					edges_q <= 2'h0;
				end else if (wr_stage[gi]) begin
					pend_q[gi] <= 1'b1;
					edges_q <= 2'h0;
				end else if (done[gi]) begin
					pend_q[gi] <= 1'b0;
				end else if (pend_q[gi] && osc_rise) begin
					edges_q <= edges_q + 2'h1;
				end
			end
		end
	endgenerate

	// Synchronous mode writes land at once; async writes wait for their transfer.
	wire logic ctrl_load = wr_ctrl && !async_q || done[`CH_CONTROL];
	wire logic cmp_load = wr_cmp && !async_q || done[`CH_COMPARE];
	wire logic cnt_load = wr_cnt && !async_q || done[`CH_COUNTER];
	wire timer_pkg::ctrl_t ctrl_new = async_q ? ctrl_stage_q : timer_pkg::ctrl_t'(wbyte);
	wire logic [7:0] cmp_new = async_q ? cmp_stage_q : wbyte;
	wire logic [7:0] cnt_new = async_q ? cnt_stage_q : wbyte;

	// ==========================================================
	// Prescaler and counter
	wire logic src_tick = async_q ? osc_rise : 1'b1;
	logic [9:0] pre_mask;
	always_comb begin
		case (ctrl_act_q.clock_prescale_sel)
			3'h1: pre_mask = 10'h000;
			3'h2: pre_mask = 10'h007;
			3'h3: pre_mask = 10'h01F;
			3'h4: pre_mask = 10'h03F;
			3'h5: pre_mask = 10'h07F;
			3'h6: pre_mask = 10'h0FF;
			3'h7: pre_mask = 10'h3FF;
			default: pre_mask = 10'h000;
		endcase
	end
	wire logic running = ctrl_act_q.clock_prescale_sel != 3'h0;
	wire logic tick = running && src_tick && ((pre_q & pre_mask) == pre_mask);

	wire timer_pkg::wave_t mode = timer_pkg::wave_t'({ctrl_act_q.wave_hi, ctrl_act_q.wave_lo});
	wire logic [1:0] com = ctrl_act_q.compare_output_mode;
	wire logic [7:0] top = (mode == timer_pkg::WAVE_CLEAR_MATCH) ? cmp_act_q : `CNT_MAX;
	wire logic at_top = cnt_q == top;
	wire logic cmp_top = cmp_act_q == top;
	wire logic match = tick && !blk_q && (cnt_q == cmp_act_q);
	wire logic pwm_ignore = com[1] && cmp_top;
	wire logic force_hit = ctrl_load && ctrl_new.force_match;

	logic [7:0] cnt_d;
	logic up_d, oc_d;
	always_comb begin
		cnt_d = cnt_q;
		up_d = up_q;
		oc_d = oc_q;
		if (tick) begin
			if (mode == timer_pkg::WAVE_PHASE_PWM) begin
				if (up_q && at_top) begin
					up_d = 1'b0;
					cnt_d = cnt_q - `CNT_ONE;
				end else if (!up_q && cnt_q == `CNT_BOTTOM) begin
					up_d = 1'b1;
					cnt_d = cnt_q + `CNT_ONE;
				end else begin
					cnt_d = up_q ? cnt_q + `CNT_ONE : cnt_q - `CNT_ONE;
				end
			end else begin
				cnt_d = at_top ? `CNT_BOTTOM : cnt_q + `CNT_ONE;
			end
		end
		case (mode)
			timer_pkg::WAVE_NORMAL, timer_pkg::WAVE_CLEAR_MATCH: begin
				if (match || force_hit) begin
					case (com)
						2'h1: oc_d = !oc_q;
						2'h2: oc_d = 1'b0;
						2'h3: oc_d = 1'b1;
						default: oc_d = oc_q;
					endcase
				end
			end
			timer_pkg::WAVE_FAST_PWM: begin
				if (com[1]) begin
					if (tick && at_top) begin
						oc_d = !com[0];
					end else if (match && !pwm_ignore) begin
						oc_d = com[0];
					end
				end
			end
			timer_pkg::WAVE_PHASE_PWM: begin
				if (com[1]) begin
					if (pwm_ignore && tick && up_q && at_top) begin
						oc_d = com[0];
					end else if (match && !pwm_ignore) begin
						oc_d = up_q ? com[0] : !com[0];
					end
				end
			end
			default: oc_d = oc_q;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_stage_q <= timer_pkg::ctrl_t'(`RST_BYTE);
			ctrl_act_q <= timer_pkg::ctrl_t'(`RST_BYTE);
			cmp_stage_q <= `RST_BYTE;
			cmp_act_q <= `RST_BYTE;
			cnt_stage_q <= `RST_BYTE;
			cnt_q <= `RST_BYTE;
			cnt_s1_q <= `RST_BYTE;
			cnt_s2_q <= `RST_BYTE;
			ext_clk_q <= 1'b0;
			async_q <= 1'b0;
			dir_q <= 1'b0;
			osc_q <= 1'b0;
			pre_q <= 10'h000;
			up_q <= 1'b1;
			blk_q <= 1'b0;
			oc_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			osc_q <= osc_in_pin;
			// The prescaler is shared, so stopping the timer does not reset its phase.
			if (src_tick) begin
				pre_q <= pre_q + 10'h001;
			end
			if (wr_ctrl) begin
				ctrl_stage_q <= timer_pkg::ctrl_t'(wbyte);
			end
			if (wr_cmp) begin
				cmp_stage_q <= wbyte;
			end
			if (wr_cnt) begin
				cnt_stage_q <= wbyte;
			end
			if (ctrl_load) begin
				ctrl_act_q <= ctrl_new;
				ctrl_act_q.force_match <= 1'b0;
			end
			if (cmp_load) begin
				cmp_act_q <= cmp_new;
			end
			if (cnt_load) begin
				cnt_q <= cnt_new;
				blk_q <= 1'b1;
			end else begin
				cnt_q <= cnt_d;
				if (tick) begin
					blk_q <= 1'b0;
				end
			end
			up_q <= up_d;
			oc_q <= oc_d;
			// A clock source switch leaves timer contents as they are; software reloads them.
			if (wr_stat) begin
				ext_clk_q <= wbyte[`ST_EXT_CLK];
				async_q <= wbyte[`ST_ASYNC];
			end
			if (wr_dir) begin
				dir_q <= wbyte[0];
			end
			// A new match outranks a clear in the same cycle.
			if (match) begin
				flag_q <= 1'b1;
			end else if (compare_vector_ack || (wr_flag && wbyte[`FLG_MATCH])) begin
				flag_q <= 1'b0;
			end
			cnt_s1_q <= cnt_q;
			cnt_s2_q <= cnt_s1_q;
		end
	end

	// ==========================================================
	// Read path and pin outputs
	wire logic [7:0] cnt_read = async_q ? cnt_s2_q : cnt_q;
	wire logic [7:0] stat_read = {3'h0, ext_clk_q, async_q, pend_q};
	logic [7:0] rbyte;
	logic r_mapped;
	always_comb begin
		r_mapped = 1'b1;
		case (ridx)
			`IDX_CONTROL: rbyte = ctrl_stage_q & 8'h7F;
			`IDX_COUNTER: rbyte = cnt_read;
			`IDX_COMPARE: rbyte = cmp_stage_q;
			`IDX_STATUS: rbyte = stat_read;
			`IDX_FLAGS: rbyte = {6'h00, flag_q, 1'b0};
			`IDX_PIN_DIR: rbyte = {7'h00, dir_q};
			default: begin
				rbyte = 8'h00;
				r_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `AXI_OKAY;
			compare_output_pin <= 1'b0;
			compare_output_oe <= 1'b0;
			ext_clk_buf_en <= 1'b0;
			crystal_osc_run <= 1'b0;
		end else begin
			if (ar_take) begin
				rvalid_q <= 1'b1;
				rdata_q <= {24'h000000, rbyte};
				rresp_q <= r_mapped ? `AXI_OKAY : `AXI_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
			compare_output_pin <= (oc_d && (com != 2'h0));
			compare_output_oe <= (com != 2'h0) && dir_q;
			ext_clk_buf_en <= ext_clk_q && async_q;
			crystal_osc_run <= !ext_clk_q && async_q;
		end
	end

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign compare_match_flag = flag_q;
endmodule : async_timer_compare_output

// File: bench/timer_chk.sv
`timescale 1ns/1ps
// ==========
// Bus handshake, flag and clock-pin checks.
module timer_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic compare_vector_ack,
	input wire logic ext_clk_buf_en,
	input wire logic crystal_osc_run,
	input wire logic compare_match_flag
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_osc_excl;
		!(ext_clk_buf_en && crystal_osc_run);
	endproperty
	a_osc_excl: assert property (p_osc_excl) else $error("buffer and crystal both on");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
	property p_ar_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
	property p_aw_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
	property p_flag_clr;
		$fell(compare_match_flag) |-> $past(compare_vector_ack) || s_axi_bvalid;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag cleared without cause");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read with data");
	property p_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_src_chg;
		$changed(ext_clk_buf_en) |-> s_axi_bvalid || $past(s_axi_bvalid);
	endproperty
	a_src_chg: assert property (p_src_chg) else $error("buffer changed without write");
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	c_flag: cover property (compare_match_flag);
	c_ext: cover property (ext_clk_buf_en);
endmodule : timer_chk

// File: bench/async_timer_compare_output_bench.sv
`timescale 1ns/1ps
`include "timer_defines.svh"
module async_timer_compare_output_bench;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, osc_in_pin, compare_vector_ack, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, compare_output_pin, compare_output_oe;
	logic ext_clk_buf_en, crystal_osc_run, compare_match_flag;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] v;
	int n_mismatch = 0;
	int comparisons = 0;
	int dv[3] = '{1, 8, 32};
	logic [9:0] ix[3] = '{`IDX_COUNTER, `IDX_COMPARE, `IDX_CONTROL};
	// Fast PWM and phase correct duty (high cycles), then clear-on-match toggles.
	logic [7:0] wave_ctl[3] = '{8'h69, 8'h61, 8'h19};
	int wave_exp[3] = '{132, 130, 8};
	int wave_tol[3] = '{8, 8, 1};
	int hi, tg;
	logic p;
	async_timer_compare_output i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.osc_in_pin, .compare_vector_ack, .compare_output_pin, .compare_output_oe,
		.ext_clk_buf_en, .crystal_osc_run, .compare_match_flag);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// ==========
	// Bus tasks. Ready is sampled at the falling edge because inputs only move on the
	// rising edge, so the value there equals the one the next rising edge sees.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge aclk);
			if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
			if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
			@(posedge aclk);
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk("bresp", `AXI_OKAY, s_axi_bresp);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] idx, output logic [7:0] d, output logic [1:0] rr);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[7:0];
		rr = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdck(input string nm, input logic [9:0] idx, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] rr;
		rd(idx, d, rr);
		chk(nm, {`AXI_OKAY, e}, {rr, d});
	endtask : rdck
	task automatic osc(input int n);
		repeat (n) begin
			repeat (4) @(posedge aclk);
			osc_in_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			osc_in_pin <= 1'b0;
		end
	endtask : osc
	task finish_test;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// ==========
	// Tests.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
		{s_axi_rready, osc_in_pin, compare_vector_ack} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rdck("control", `IDX_CONTROL, 8'h00);
		rdck("compare", `IDX_COMPARE, 8'h00);
		rdck("status", `IDX_STATUS, 8'h00);
		rd(10'h0A0, v, r);
		chk("unmapped", {`AXI_SLVERR, 8'h00}, {r, v});
		wr(`IDX_PIN_DIR, 8'h01);
		wr(`IDX_COMPARE, 8'h30);
		wr(`IDX_CONTROL, 8'h31);
		repeat (300) @(posedge aclk);
		chk("pin set", 1'b1, compare_output_pin);
		chk("oe", 1'b1, compare_output_oe);
		chk("flag", 1'b1, compare_match_flag);
		wr(`IDX_CONTROL, 8'h21);
		repeat (300) @(posedge aclk);
		chk("pin clear", 1'b0, compare_output_pin);
		wr(`IDX_CONTROL, 8'h20);
		wr(`IDX_FLAGS, 8'h02);
		rdck("flags", `IDX_FLAGS, 8'h00);
		wr(`IDX_CONTROL, 8'h21);
		repeat (300) @(posedge aclk);
		wr(`IDX_CONTROL, 8'h20);
		chk("flag again", 1'b1, compare_match_flag);
		compare_vector_ack <= 1'b1;
		@(posedge aclk);
		compare_vector_ack <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("ack", 1'b0, compare_match_flag);
		wr(`IDX_COUNTER, 8'h40);
		rdck("counter", `IDX_COUNTER, 8'h40);
		rdck("stopped", `IDX_COUNTER, 8'h40);
		// The bus cycles add a few undivided clocks, hence the slack above the count.
		for (int i = 0; i < 3; i++) begin
			wr(`IDX_COUNTER, 8'h00);
			wr(`IDX_CONTROL, 8'(i + 1));
			repeat (160) @(posedge aclk);
			wr(`IDX_CONTROL, 8'h00);
			rd(`IDX_COUNTER, v, r);
			comparisons++;
			if (v < 160 / dv[i] || v > 160 / dv[i] + 6) begin
				n_mismatch++;
				$display("ERROR prescale expected %0d seen %0d", 160 / dv[i], v);
			end
		end
		// A window of 520 cycles holds exactly eight clear-on-match periods at top 0x40.
		wr(`IDX_COMPARE, 8'h40);
		for (int i = 0; i < 3; i++) begin
			wr(`IDX_CONTROL, wave_ctl[i]);
			repeat (300) @(posedge aclk);
			hi = 0;
			tg = 0;
			@(negedge aclk);
			p = compare_output_pin;
			repeat (520) begin
				@(negedge aclk);
				hi += compare_output_pin;
				tg += (compare_output_pin != p);
				p = compare_output_pin;
			end
			if (i == 2) hi = tg;
			comparisons++;
			if (hi < wave_exp[i] - wave_tol[i] || hi > wave_exp[i] + wave_tol[i]) begin
				n_mismatch++;
				$display("ERROR waveform expected %0d seen %0d", wave_exp[i], hi);
			end
		end
		wr(`IDX_CONTROL, 8'h00);
		wr(`IDX_STATUS, 8'h08);
		rdck("async", `IDX_STATUS, 8'h08);
		chk("crystal", 2'h1, {ext_clk_buf_en, crystal_osc_run});
		for (int i = 0; i < 3; i++) begin
			wr(ix[i], 8'h10);
			rdck("pending", `IDX_STATUS, 8'h08 | (8'h04 >> i));
			osc(1);
			rdck("one edge", `IDX_STATUS, 8'h08 | (8'h04 >> i));
			osc(1);
			rdck("two edges", `IDX_STATUS, 8'h08);
		end
		rdck("staged", `IDX_COMPARE, 8'h10);
		rdck("async count", `IDX_COUNTER, 8'h10);
		wr(`IDX_STATUS, 8'h00);
		wr(`IDX_STATUS, 8'h10);
		wr(`IDX_STATUS, 8'h18);
		repeat (2) @(posedge aclk);
		chk("ext clock", 2'h2, {ext_clk_buf_en, crystal_osc_run});
		finish_test;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		finish_test;
	end
endmodule : async_timer_compare_output_bench
bind async_timer_compare_output timer_chk i_chk (.aclk, .aresetn, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_vector_ack, .ext_clk_buf_en,
	.crystal_osc_run, .compare_match_flag);
